/* File: tcc_defs.vh */
// Register map, field layout and codes for the capture/compare channel pair
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH

`define TCC_OFF_CFG1    8'h00
`define TCC_OFF_CFG2    8'h04
`define TCC_OFF_SLAVE   8'h08
`define TCC_OFF_STATUS  8'h0c
`define TCC_OFF_EVENT   8'h10
`define TCC_OFF_CCR1H   8'h14
`define TCC_OFF_CCR1L   8'h18
`define TCC_OFF_CCR2H   8'h1c
`define TCC_OFF_CCR2L   8'h20
`define TCC_OFF_STATE   8'h24

`define TCC_CFG_W       15
`define TCC_CFG_RESET   15'h0000
`define TCC_SEL_LSB     0
`define TCC_PSC_LSB     2
`define TCC_FLT_LSB     4
`define TCC_OM_LSB      8
`define TCC_PE_BIT      11
`define TCC_POL_BIT     12
`define TCC_EN_BIT      13
`define TCC_IE_BIT      14

`define TCC_SEL_OUT     2'h0
`define TCC_SEL_OWN     2'h1
`define TCC_SEL_OTHER   2'h2

`define TCC_OM_HOLD     3'h0
`define TCC_OM_SET      3'h1
`define TCC_OM_CLEAR    3'h2
`define TCC_OM_TOGGLE   3'h3
`define TCC_OM_FORCE_LO 3'h4
`define TCC_OM_FORCE_HI 3'h5

`define TCC_TS_LSB      0
`define TCC_SMS_LSB     4
`define TCC_SLAVE_RESET 7'h00
`define TCC_TS_CH1_EDGE 3'h5
`define TCC_TS_CH2_EDGE 3'h6
`define TCC_SMS_RESET   3'h4

`define TCC_FLT_STEP    3'h0

`endif

/* File: tcc_input_filter.v */
// Digital input filter: a new level passes after N equal consecutive samples
`timescale 1ns/1ns
`include "tcc_defs.vh"
module tcc_input_filter (
  input  wire       clk_sys,
  input  wire       reset_n,
  input  wire       sampleIn,
  input  wire [3:0] filterSetting,
  output reg        filtered
);
  reg  [6:0] runLength;
  wire [6:0] needed;

  // 0:1, 1:2, 2:4, 3:8 samples, then steps of eight up to 104
  assign needed = (filterSetting == 4'h0) ? 7'h01 :
                  (filterSetting < 4'h4) ? (7'h01 << filterSetting[1:0]) :
                  {filterSetting - 4'h2, `TCC_FLT_STEP};

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      filtered  <= 1'b0;
      runLength <= 7'h00;
    end else if (sampleIn == filtered) begin
      runLength <= 7'h00;
    end else if ((runLength + 7'h01) == needed) begin
      filtered  <= sampleIn;
      runLength <= 7'h00;
    end else begin
      runLength <= runLength + 7'h01;
    end
  end
endmodule

/* File: tcc_channel.v */
// Two capture/compare channels with APB registers, input stage and output stage
`timescale 1ns/1ns
`include "tcc_defs.vh"
module tcc_channel (
  input  wire        clk_sys,
  input  wire        reset_n,
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [1:0]  channelPin,
  input  wire [15:0] counterValue,
  input  wire        updateEvent,
  output reg  [1:0]  channelOut,
  output reg  [1:0]  channelOutEnable,
  output wire [1:0]  captureIrq,
  output reg         triggerEdge,
  output reg         counterReset
);
  wire       access  = psel & penable;
  wire       wrStrobe = access & pwrite;
  wire       rdStrobe = access & ~pwrite;
  reg        addrHit;

  reg  [1:0] pinMeta;
  reg  [1:0] pinSync;
  wire [1:0] filtered;
  reg  [1:0] filtPrev;

  reg  [6:0] slaveCfg;
  reg  [1:0] captureFlag;
  reg  [1:0] overcaptureFlag;

  wire [1:0]  capEvent;
  wire [1:0]  captureTaken;
  wire [1:0]  lowReadClear;
  wire [1:0]  irqEnable;
  wire [1:0]  refWave;
  wire [1:0]  hiPendingView;
  wire [1:0]  readLockView;
  wire [1:0]  ch1EdgeView;
  wire [31:0] ccrView;
  wire [29:0] cfgView;

  wire       wrStatus = wrStrobe & (paddr == `TCC_OFF_STATUS);
  wire       wrEvent  = wrStrobe & (paddr == `TCC_OFF_EVENT);
  wire [1:0] swGen    = wrEvent ? pwdata[1:0] : 2'h0;
  wire [1:0] capClear = (wrStatus ? ~pwdata[1:0] : 2'h0) | lowReadClear;
  wire [1:0] ovClear  = wrStatus ? ~pwdata[3:2] : 2'h0;

  assign pready  = 1'b1;
  assign pslverr = access & ~addrHit;
  assign captureIrq = captureFlag & irqEnable;

  always @* begin
    case (paddr)
      `TCC_OFF_CFG1, `TCC_OFF_CFG2, `TCC_OFF_SLAVE, `TCC_OFF_STATUS,
      `TCC_OFF_EVENT, `TCC_OFF_CCR1H, `TCC_OFF_CCR1L, `TCC_OFF_CCR2H,
      `TCC_OFF_CCR2L, `TCC_OFF_STATE: addrHit = 1'b1;
      default: addrHit = 1'b0;
    endcase
  end

  // Read data is captured in the setup phase so it stands for the access phase
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      case (paddr)
        `TCC_OFF_CFG1:   prdata <= {17'h00000, cfgView[14:0]};
        `TCC_OFF_CFG2:   prdata <= {17'h00000, cfgView[29:15]};
        `TCC_OFF_SLAVE:  prdata <= {25'h0000000, slaveCfg};
        `TCC_OFF_STATUS: prdata <= {28'h0000000, overcaptureFlag, captureFlag};
        `TCC_OFF_CCR1H:  prdata <= {24'h000000, ccrView[15:8]};
        `TCC_OFF_CCR1L:  prdata <= {24'h000000, ccrView[7:0]};
        `TCC_OFF_CCR2H:  prdata <= {24'h000000, ccrView[31:24]};
        `TCC_OFF_CCR2L:  prdata <= {24'h000000, ccrView[23:16]};
        `TCC_OFF_STATE:  prdata <= {22'h000000, channelOut, readLockView,
                                    hiPendingView, refWave, filtered};
        default:         prdata <= 32'h00000000;
      endcase
    end
  end

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      pinMeta  <= 2'h0;
      pinSync  <= 2'h0;
      filtPrev <= 2'h0;
      slaveCfg <= `TCC_SLAVE_RESET;
    end else begin
      pinMeta  <= channelPin;
      pinSync  <= pinMeta;
      filtPrev <= filtered;
      if (wrStrobe && paddr == `TCC_OFF_SLAVE)
        slaveCfg <= pwdata[6:0];
    end
  end

  // A flag raised in the same cycle as its clear stays set
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      captureFlag     <= 2'h0;
      overcaptureFlag <= 2'h0;
    end else begin
      captureFlag     <= (captureFlag & ~capClear) | capEvent;
      overcaptureFlag <= (overcaptureFlag & ~ovClear) |
                         (captureTaken & captureFlag);
    end
  end

  // Slave controller hook: trigger from a channel edge path, reset mode
  wire [2:0] trigSel   = slaveCfg[`TCC_TS_LSB +: 3];
  wire [2:0] slaveMode = slaveCfg[`TCC_SMS_LSB +: 3];
  wire       trigNow   = (trigSel == `TCC_TS_CH1_EDGE) ? ch1EdgeView[0] :
                         (trigSel == `TCC_TS_CH2_EDGE) ? ch1EdgeView[1] : 1'b0;

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      triggerEdge  <= 1'b0;
      counterReset <= 1'b0;
    end else begin
      triggerEdge  <= trigNow;
      counterReset <= trigNow & (slaveMode == `TCC_SMS_RESET);
    end
  end

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : gen_ch
      reg  [`TCC_CFG_W-1:0] cfg;
      reg  [15:0] preload;
      reg  [15:0] shadow;
      reg         hiPending;
      reg         readLock;
      reg  [2:0]  pscCount;
      reg         matchPrev;
      reg         refOut;
      reg         nextRef;

      wire [1:0] sel     = cfg[`TCC_SEL_LSB +: 2];
      wire [1:0] psc     = cfg[`TCC_PSC_LSB +: 2];
      wire [2:0] om      = cfg[`TCC_OM_LSB +: 3];
      wire       preEn   = cfg[`TCC_PE_BIT];
      wire       pol     = cfg[`TCC_POL_BIT];
      wire       enable  = cfg[`TCC_EN_BIT];
      wire [7:0] cfgAddr = (i == 0) ? `TCC_OFF_CFG1 : `TCC_OFF_CFG2;
      wire [7:0] hiAddr  = (i == 0) ? `TCC_OFF_CCR1H : `TCC_OFF_CCR2H;
      wire [7:0] loAddr  = (i == 0) ? `TCC_OFF_CCR1L : `TCC_OFF_CCR2L;
      wire       wrHi    = wrStrobe & (paddr == hiAddr);
      wire       wrLo    = wrStrobe & (paddr == loAddr);
      wire       rdHi    = psel & ~penable & ~pwrite & (paddr == hiAddr);
      wire       rdLo    = rdStrobe & (paddr == loAddr);

      wire inputMode = (sel == `TCC_SEL_OWN) | (sel == `TCC_SEL_OTHER);
      // Selection 11 parks the channel: no capture and no pin drive
      wire outMode   = (sel == `TCC_SEL_OUT);
      wire srcCur    = (sel == `TCC_SEL_OTHER) ? filtered[1-i] : filtered[i];
      wire srcPrev   = (sel == `TCC_SEL_OTHER) ? filtPrev[1-i] : filtPrev[i];
      wire edgeSeen  = pol ? (srcPrev & ~srcCur) : (~srcPrev & srcCur);
      wire ownEdge   = pol ? (filtPrev[i] & ~filtered[i]) : (~filtPrev[i] & filtered[i]);

      wire [2:0] pscLast = (3'h1 << psc) - 3'h1;
      wire       active  = inputMode & enable;
      wire       pscHit  = active & edgeSeen & (pscCount == pscLast);
      wire       capture = active & (pscHit | swGen[i]);

      wire matchNow = ~inputMode & (counterValue == shadow);
      wire match    = matchNow & ~matchPrev;

      tcc_input_filter u_filter (
        .clk_sys       (clk_sys),
        .reset_n       (reset_n),
        .sampleIn      (pinSync[i]),
        .filterSetting (cfg[`TCC_FLT_LSB +: 4]),
        .filtered      (filtered[i])
      );

      assign capEvent[i]      = capture | match | (swGen[i] & ~inputMode);
      assign captureTaken[i]  = capture;
      assign lowReadClear[i]  = rdLo & inputMode;
      assign irqEnable[i]     = cfg[`TCC_IE_BIT];
      assign refWave[i]       = refOut;
      assign hiPendingView[i] = hiPending;
      assign readLockView[i]  = readLock;
      assign ch1EdgeView[i]   = ownEdge;
      assign ccrView[i*16 +: 16]  = preload;
      assign cfgView[i*15 +: 15]  = cfg;

      always @* begin
        nextRef = refOut;
        case (om)
          `TCC_OM_HOLD:     nextRef = refOut;
          `TCC_OM_SET:      if (match) nextRef = 1'b1;
          `TCC_OM_CLEAR:    if (match) nextRef = 1'b0;
          `TCC_OM_TOGGLE:   if (match) nextRef = ~refOut;
          `TCC_OM_FORCE_LO: nextRef = 1'b0;
          `TCC_OM_FORCE_HI: nextRef = 1'b1;
          default:          nextRef = refOut;
        endcase
      end

      always @(posedge clk_sys) begin
        if (!reset_n) begin
          cfg       <= `TCC_CFG_RESET;
          pscCount  <= 3'h0;
          matchPrev <= 1'b0;
          refOut    <= 1'b0;
        end else begin
          if (wrStrobe && paddr == cfgAddr)
            cfg <= pwdata[`TCC_CFG_W-1:0];
          if (!active)
            pscCount <= 3'h0;
          else if (edgeSeen)
            pscCount <= (pscCount == pscLast) ? 3'h0 : pscCount + 3'h1;
          matchPrev <= matchNow;
          // Reference only changes by mode or match, never by update event
          refOut    <= ~inputMode & nextRef;
        end
      end

      always @(posedge clk_sys) begin
        if (!reset_n) begin
          preload   <= 16'h0000;
          shadow    <= 16'h0000;
          hiPending <= 1'b0;
          readLock  <= 1'b0;
        end else if (inputMode) begin
          hiPending <= 1'b0;
          // Software writes are dropped: the capture value is read-only here
          if (capture)
            shadow <= counterValue;
          // Freeze starts in the high-byte setup cycle, when its read data is loaded,
          // so a capture there cannot split the pair
          if (rdHi)
            readLock <= 1'b1;
          else if (rdLo)
            readLock <= 1'b0;
          if (!readLock && !rdHi)
            preload <= capture ? counterValue : shadow;
        end else begin
          readLock <= 1'b0;
          if (wrHi) begin
            preload[15:8] <= pwdata[7:0];
            hiPending     <= 1'b1;
          end else if (wrLo) begin
            preload[7:0] <= pwdata[7:0];
            hiPending    <= 1'b0;
            if (!preEn)
              shadow <= {preload[15:8], pwdata[7:0]};
          end else if (updateEvent && preEn && !hiPending) begin
            shadow <= preload;
          end
        end
      end

      // Polarity and enable sit at the very end of the output chain
      always @(posedge clk_sys) begin
        if (!reset_n) begin
          channelOut[i]       <= 1'b0;
          channelOutEnable[i] <= 1'b0;
        end else begin
          channelOut[i]       <= enable & outMode & (refOut ^ pol);
          channelOutEnable[i] <= enable & outMode;
        end
      end
    end
  endgenerate
endmodule

/* File: tcc_channel_asserts.sv */
// Port-level assertions for the capture/compare channel pair
`timescale 1ns/1ns
`include "tcc_defs.vh"
module tcc_channel_asserts (
  input wire        clk_sys,
  input wire        reset_n,
  input wire [7:0]  paddr,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] pwdata,
  input wire [1:0]  channelPin,
  input wire [1:0]  channelOut,
  input wire [1:0]  channelOutEnable,
  input wire [1:0]  captureIrq,
  input wire        triggerEdge,
  input wire        counterReset
);
  reg  [14:0] cfgA;
  reg  [6:0]  slvA;
  reg  [1:0]  cfgAge;
  reg  [4:0]  pinRun;
  reg         pinPrev;
  wire        cfgWr = psel && penable && pwrite && paddr == `TCC_OFF_CFG1;
  wire        settled = cfgAge == 2'h3;
  wire        drive = settled && cfgA[13] && cfgA[1:0] == `TCC_SEL_OUT;
  wire [2:0]  om = cfgA[10:8];
  wire        pol = cfgA[12];
  wire        ch1Trig = slvA[2:0] == `TCC_TS_CH1_EDGE && cfgA[7:4] == 4'h3;
  // Outputs lag a configuration write by up to two edges, so judge only once settled
  always @(posedge clk_sys) begin
    if (!reset_n || cfgWr)
      cfgAge <= reset_n ? 2'h0 : 2'h3;
    else if (!settled)
      cfgAge <= cfgAge + 2'h1;
    if (!reset_n)
      cfgA <= `TCC_CFG_RESET;
    else if (cfgWr)
      cfgA <= pwdata[14:0];
    if (!reset_n)
      slvA <= `TCC_SLAVE_RESET;
    else if (psel && penable && pwrite && paddr == `TCC_OFF_SLAVE)
      slvA <= pwdata[6:0];
    pinPrev <= channelPin[0];
    pinRun <= (channelPin[0] != pinPrev) ? 5'h00 : pinRun + {4'h0, pinRun != 5'h1f};
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  a_drive_enable: assert property (settled |-> channelOutEnable[0] == drive)
    else $error("output enable wrong");
  a_input_quiet: assert property (settled && cfgA[1:0] == `TCC_SEL_OWN |-> !channelOut[0])
    else $error("input channel drives pin");
  a_force_hi: assert property (drive && om == `TCC_OM_FORCE_HI |-> channelOut[0] != pol)
    else $error("forced high level wrong");
  a_force_lo: assert property (drive && om == `TCC_OM_FORCE_LO |-> channelOut[0] == pol)
    else $error("forced low level wrong");
  a_irq_masked: assert property (!cfgA[14] |-> !captureIrq[0])
    else $error("masked interrupt raised");
  a_trig_pulse: assert property (triggerEdge |=> !triggerEdge)
    else $error("trigger longer than one cycle");
  a_reset_cause: assert property (counterReset |-> slvA[6:4] == `TCC_SMS_RESET && (triggerEdge || $past(triggerEdge)))
    else $error("counter reset without trigger");
  a_filter_hold: assert property (triggerEdge && ch1Trig |-> pinRun >= 5'd8)
    else $error("edge passed filter too soon");
  c_period: cover property (counterReset);
  c_forced: cover property (drive && om == `TCC_OM_FORCE_HI);
  c_both_irq: cover property (captureIrq == 2'b11);
endmodule
bind tcc_channel tcc_channel_asserts chk_u (.clk_sys(clk_sys), .reset_n(reset_n),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .channelPin(channelPin), .channelOut(channelOut), .channelOutEnable(channelOutEnable),
  .captureIrq(captureIrq), .triggerEdge(triggerEdge), .counterReset(counterReset));

/* File: tcc_pin_model.sv */
// Far-side pin driver: glitchy PWM on the channel-1 pin
`timescale 1ns/1ns
module tcc_pin_model (
  input  wire       clk_sys,
  input  wire       run,
  input  wire [7:0] lowLen,
  input  wire [7:0] highLen,
  output reg  [1:0] channelPin
);
  reg  [8:0] phase = 9'h000;
  wire [8:0] k = phase - {1'b0, lowLen};
  initial channelPin = 2'b00;
  always @(posedge clk_sys) begin
    phase <= (!run || k == {1'b0, highLen} - 9'h001) ? 9'h000 : phase + 9'h001;
    // One-cycle blip, three low samples, then a steady high level
    channelPin[0] <= run && phase >= {1'b0, lowLen} && (k == 9'h000 || k > 9'h003);
    channelPin[1] <= run && phase < {1'b0, lowLen};
  end
endmodule

/* File: tcc_testbench.sv */
// Self-checking bench: APB master, counter, compare and capture scenarios
`timescale 1ns/1ns
`include "tcc_defs.vh"
module testbench;
  reg         clk_sys = 1'b0;
  reg         reset_n = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [31:0] pwdata = 32'h0;
  reg  [15:0] counterValue = 16'h0;
  reg         updateEvent = 1'b0;
  reg         run = 1'b0;
  reg  [7:0]  lo = 8'h14;
  reg  [7:0]  hi = 8'h14;
  reg  [31:0] rdv;
  reg         errv;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire [1:0]  channelPin;
  wire [1:0]  channelOut;
  wire [1:0]  captureIrq;
  wire        counterReset;
  integer     failures = 0;
  integer     total_checks = 0;
  integer     seed, m, r, pol, t, c1, c2;
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) counterValue <= counterReset ? 16'h0 : counterValue + 16'h1;
  tcc_channel dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .channelPin(channelPin), .counterValue(counterValue),
    .updateEvent(updateEvent), .channelOut(channelOut), .channelOutEnable(),
    .captureIrq(captureIrq), .triggerEdge(), .counterReset(counterReset));
  tcc_pin_model pin_u (.clk_sys(clk_sys), .run(run), .lowLen(lo), .highLen(hi),
    .channelPin(channelPin));
  function [31:0] cfgw(input ie, en, pl, pe, input [2:0] om, input [3:0] f, input [1:0] s);
    cfgw = {17'h0, ie, en, pl, pe, om, f, 2'b00, s};
  endfunction
  task tally_and_finish;
    begin
      if (failures == 0 && total_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      @(posedge clk_sys);
      while (pready !== 1'b1 && n < 50) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      chk(n < 50, 1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task ccr(input [15:0] v);
    begin
      apb(1, `TCC_OFF_CCR1H, v[15:8]);
      apb(1, `TCC_OFF_CCR1L, v[7:0]);
    end
  endtask
  task rdccr(input [7:0] a, output integer v);
    begin
      apb(0, a, 0);
      v = rdv[7:0] * 256;
      apb(0, a + 8'h04, 0);
      v = v + rdv[7:0];
    end
  endtask
  task upd;
    begin
      updateEvent <= 1'b1;
      @(posedge clk_sys);
      updateEvent <= 1'b0;
    end
  endtask
  task waitcnt(input [15:0] v);
    integer n;
    begin
      for (n = 0; counterValue !== v && n < 2000; n = n + 1)
        @(posedge clk_sys);
      chk(n < 2000, 1);
      repeat (4) @(posedge clk_sys);
    end
  endtask
  // Whole run is under two thousand cycles; twenty thousand means a hang
  initial begin
    #800000;
    failures = failures + 1;
    tally_and_finish;
  end
  initial begin
    seed = 2898;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    apb(0, 8'h80, 0);
    chk(rdv, 32'h0);
    chk(errv, 1);
    r = 0;
    for (m = 0; m < 6; m = m + 1) begin
      pol = $random(seed) & 1;
      apb(1, `TCC_OFF_STATUS, 0);
      apb(1, `TCC_OFF_CFG1, cfgw(1, 1, pol, 0, m, 0, `TCC_SEL_OUT));
      t = counterValue + 30;
      ccr(t);
      waitcnt(t);
      r = (m == 1 || m == 5) ? 1 : (m == 2 || m == 4) ? 0 : (m == 3) ? !r : r;
      chk(channelOut[0], r ^ pol);
      chk(captureIrq[0], 1);
    end
    apb(1, `TCC_OFF_CFG1, cfgw(1, 1, 0, 1, `TCC_OM_TOGGLE, 0, `TCC_SEL_OUT));
    t = counterValue + 40;
    // Preload already holds t, so an update that ignored the pending high byte would match
    ccr(t);
    apb(1, `TCC_OFF_CCR1H, t[15:8]);
    upd;
    apb(1, `TCC_OFF_CCR1L, t[7:0]);
    waitcnt(t);
    chk(channelOut[0], r);
    t = counterValue + 40;
    ccr(t);
    upd;
    repeat (3) @(posedge clk_sys);
    chk(channelOut[0], r);
    waitcnt(t);
    chk(channelOut[0], !r);
    lo = 20 + ($random(seed) & 31);
    hi = 20 + ($random(seed) & 31);
    apb(1, `TCC_OFF_SLAVE, {`TCC_SMS_RESET, 1'b0, `TCC_TS_CH1_EDGE});
    apb(1, `TCC_OFF_CFG1, cfgw(1, 1, 0, 0, 0, 3, `TCC_SEL_OWN));
    apb(1, `TCC_OFF_CFG2, cfgw(1, 1, 1, 0, 0, 3, `TCC_SEL_OTHER));
    run <= 1'b1;
    repeat (4 * (lo + hi)) @(posedge clk_sys);
    chk(captureIrq, 2'b11);
    apb(0, `TCC_OFF_STATUS, 0);
    chk(rdv[3:0], 4'hf);
    rdccr(`TCC_OFF_CCR1H, c1);
    rdccr(`TCC_OFF_CCR2H, c2);
    chk(c1 - c2, lo + 4);
    chk(c1 <= lo + hi && c1 + 8 >= lo + hi, 1);
    run <= 1'b0;
    repeat (3 * (lo + hi)) @(posedge clk_sys);
    apb(0, `TCC_OFF_CCR1L, 0);
    c1 = rdv;
    apb(0, `TCC_OFF_CCR2L, 0);
    apb(0, `TCC_OFF_STATUS, 0);
    chk(rdv[3:0], 4'hc);
    apb(1, `TCC_OFF_STATUS, 3);
    apb(1, `TCC_OFF_CCR1L, ~c1);
    apb(0, `TCC_OFF_STATUS, 0);
    chk(rdv[3:0], 4'h0);
    apb(0, `TCC_OFF_CCR1L, 0);
    chk(rdv, c1);
    apb(1, `TCC_OFF_CFG1, cfgw(0, 1, 0, 0, 0, 3, `TCC_SEL_OWN));
    apb(1, `TCC_OFF_CFG2, cfgw(1, 0, 1, 0, 0, 3, `TCC_SEL_OTHER));
    run <= 1'b1;
    repeat (3 * (lo + hi)) @(posedge clk_sys);
    chk(captureIrq, 2'b00);
    apb(0, `TCC_OFF_STATUS, 0);
    chk(rdv[1:0], 2'h1);
    tally_and_finish;
  end
endmodule
